// File: bench/ppo_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_top_tb;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [7:0]  pwm_o;
  logic        period_start_o;
  int          error_cnt;
  int          cmp_count;
  logic [31:0] rd;
  int          c;

  ppo_top ppo_top_inst (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .cyc_i          (cyc_i),
    .stb_i          (stb_i),
    .we_i           (we_i),
    .adr_i          (adr_i),
    .sel_i          (sel_i),
    .dat_i          (dat_i),
    .dat_o          (dat_o),
    .ack_o          (ack_o),
    .pwm_o          (pwm_o),
    .period_start_o (period_start_o)
  );

  always #50 clk_i = ~clk_i;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle, waits for ack; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wait_boundary();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (period_start_o !== 1'b1 && n < 400);
    if (n >= 400) chk(32'h0, 32'h1);
  endtask

  // active cycles of one output over one 10-cycle period
  task automatic count_hi(input int b, output int cnt);
    cnt = 0;
    repeat (10) begin
      @(posedge clk_i);
      if (pwm_o[b] === 1'b1) cnt++;
    end
  endtask

  task automatic t_reset();
    wb(1'b0, 8'h28, 32'h0, rd);
    chk(rd, 32'h000000FF);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h00000000);
    chk({24'h0, pwm_o}, 32'h000000AA);
    $display("test reset done");
  endtask

  task automatic t_duty_regs();
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'(8 * k), 32'h000000FF, rd);
      wb(1'b1, 8'(8 * k + 4), 32'h000000FF, rd);
      wb(1'b0, 8'(8 * k), 32'h0, rd);
      chk(rd, 32'h000000FF);
      wb(1'b0, 8'(8 * k + 4), 32'h0, rd);
      chk(rd, 32'h0000003F);
    end
    wb(1'b0, 8'h30, 32'h0, rd);
    chk(rd, 32'h00000000);
    $display("test duty registers done");
  endtask

  task automatic t_compare();
    wb(1'b1, 8'h28, 32'h00000009, rd);
    wb(1'b1, 8'h00, 32'h00000003, rd);
    wb(1'b1, 8'h04, 32'h00000000, rd);
    repeat (3) wait_boundary();
    count_hi(0, c);
    chk(32'(c), 32'h00000003);
    count_hi(1, c);
    chk(32'(c), 32'h00000007);
    $display("test duty compare done");
  endtask

  task automatic t_override();
    wb(1'b1, 8'h24, 32'h00000001, rd);
    wait_boundary();
    wb(1'b1, 8'h20, 32'h00000001, rd);
    @(posedge clk_i);
    @(posedge clk_i);
    chk({31'h0, pwm_o[0]}, 32'h00000000);
    wait_boundary();
    repeat (2) @(posedge clk_i);
    count_hi(0, c);
    chk(32'(c), 32'h0000000A);
    count_hi(1, c);
    chk(32'(c), 32'h00000007);
    wb(1'b0, 8'h2C, 32'h0, rd);
    chk(rd & 32'h0000FFFD, 32'h00000155);
    chk({31'h0, rd[29:16] <= 14'h0009}, 32'h00000001);
    wb(1'b1, 8'h24, 32'h00000000, rd);
    repeat (2) @(posedge clk_i);
    count_hi(0, c);
    chk(32'(c), 32'h00000000);
    wb(1'b1, 8'h20, 32'h00000000, rd);
    repeat (2) wait_boundary();
    count_hi(0, c);
    chk(32'(c), 32'h00000003);
    $display("test override done");
  endtask

  task automatic t_mid_reset();
    wb(1'b1, 8'h24, 32'h00000001, rd);
    wb(1'b1, 8'h20, 32'h00000001, rd);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h00000000);
    wb(1'b0, 8'h28, 32'h0, rd);
    chk(rd, 32'h000000FF);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h00000000);
    chk({24'h0, pwm_o}, 32'h000000AA);
    $display("test mid-run reset done");
  endtask

  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_duty_regs();
    t_compare();
    t_override();
    t_mid_reset();
    end_of_test();
  end
endmodule

`default_nettype wire

// File: rtl/ppo_pkg.sv
`default_nettype none

package ppo_pkg;
  // generator and output counts, duty width and range
  localparam int N_GEN    = 4;
  localparam int N_OUT    = 8;
  localparam int DUTY_W   = 14;
  localparam int DUTY_MAX = 16383;
  localparam int HI_W     = DUTY_W - 8;

  // register byte addresses
  localparam logic [7:0] OFF_DUTY_LO = 8'h00;
  localparam logic [7:0] OFF_DUTY_HI = 8'h04;
  localparam logic [7:0] DUTY_STRIDE = 8'h08;
  localparam logic [7:0] OFF_OVR_EN  = 8'h20;
  localparam logic [7:0] OFF_OVR_LVL = 8'h24;
  localparam logic [7:0] OFF_PERIOD  = 8'h28;
  localparam logic [7:0] OFF_STATUS  = 8'h2C;

  // field positions in the status word
  localparam int STAT_PWM_LSB = 0;
  localparam int STAT_OVA_LSB = 8;
  localparam int STAT_TB_LSB  = 16;

  // reset values
  localparam logic [13:0] DUTY_RST   = 14'h0000;
  localparam logic [13:0] PERIOD_RST = 14'h00FF;
  localparam logic [7:0]  OVR_RST    = 8'h00;

  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ppo_wb_req_type;

  typedef struct packed {
    logic [7:0]  ovr_en;
    logic [7:0]  ovr_lvl;
    logic [13:0] period;
  } ppo_ctl_type;
endpackage

`default_nettype wire

// File: rtl/ppo_top.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Duty registers exist for generators 0, 1, 2 and 3, each taking 0 to 16383 in 14 bits.
// - The stored duty is how long the generator's even output stays active in each period; its odd output is the complement.
// - Each duty value lives in a low-byte and a high-byte register of its generator.
// - Each of the eight outputs, indexed 0 to 7, has its own override control.
// - With override off an output follows its generator's duty comparison.
// - With override on an output ignores the comparison and follows the override level.
// - Override on with level 1 makes the output active only from the next period boundary.
// - Override on with level 0 holds the output inactive.
module ppo_top #(
  parameter int DUTY_W = ppo_pkg::DUTY_W
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // pwm outputs, active high
  output logic      [7:0]  pwm_o,
  output logic             period_start_o
);

  if (DUTY_W != 14) begin : g_bad_width
    $error("ppo_top: DUTY_W must be 14");
  end

  if (ppo_pkg::N_OUT != 2 * ppo_pkg::N_GEN) begin : g_bad_count
    $error("ppo_top: N_OUT must be twice N_GEN");
  end

  // merge one byte lane into a stored field
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    merge_byte = en ? new_v : old_v;
  endfunction

  // generator slot of a duty register address
  function automatic logic [1:0] gen_of(input logic [7:0] adr);
    gen_of = adr[4:3];
  endfunction

  // word-aligned address inside the duty block
  function automatic logic is_duty_adr(input logic [7:0] adr);
    is_duty_adr = (adr < ppo_pkg::OFF_OVR_EN) && (adr[1:0] == 2'b00);
  endfunction

  ppo_pkg::ppo_wb_req_type req;
  ppo_pkg::ppo_ctl_type    ctl;
  ppo_pkg::ppo_ctl_type    next_ctl;
  logic [13:0] duty      [4];
  logic [13:0] next_duty [4];
  // active copies reload only at a period boundary
  logic [13:0] duty_act      [4];
  logic [13:0] next_duty_act [4];
  logic [13:0] tb;
  logic [13:0] next_tb;
  logic [7:0]  ov_act;
  logic [7:0]  next_ov_act;
  logic [7:0]  next_pwm;
  logic        next_ps;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdat;
  logic [31:0] next_rdat;
  logic        acc;
  logic        bnd;
  logic [7:0]  base;

  assign req   = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
  // ack gates acceptance, so back to back requests see a gap
  assign acc   = cyc_i & stb_i & ~ack;
  assign ack_o = ack;
  assign dat_o = rdat;

  // register access
  always_comb begin
    logic [1:0] g;
    logic [7:0] hb;
    g = gen_of(req.adr);
    hb = 8'h00;
    next_ctl = ctl;
    next_duty = duty;
    next_ack = acc;
    next_rdat = 32'h0000_0000;
    if (acc && is_duty_adr(req.adr)) begin
      if (req.adr[2] == 1'b0) begin
        if (req.we) begin
          next_duty[g][7:0] = merge_byte(duty[g][7:0], req.dat[7:0], req.sel[0]);
        end
        next_rdat[7:0] = duty[g][7:0];
      end else begin
        hb = merge_byte({2'b00, duty[g][13:8]}, req.dat[7:0], req.sel[0]);
        if (req.we) begin
          next_duty[g][13:8] = hb[ppo_pkg::HI_W-1:0];
        end
        next_rdat[ppo_pkg::HI_W-1:0] = duty[g][13:8];
      end
    end else if (acc) begin
      case (req.adr)
        ppo_pkg::OFF_OVR_EN: begin
          if (req.we) begin
            next_ctl.ovr_en = merge_byte(ctl.ovr_en, req.dat[7:0], req.sel[0]);
          end
          next_rdat[7:0] = ctl.ovr_en;
        end
        ppo_pkg::OFF_OVR_LVL: begin
          if (req.we) begin
            next_ctl.ovr_lvl = merge_byte(ctl.ovr_lvl, req.dat[7:0], req.sel[0]);
          end
          next_rdat[7:0] = ctl.ovr_lvl;
        end
        ppo_pkg::OFF_PERIOD: begin
          if (req.we) begin
            next_ctl.period[7:0] = merge_byte(ctl.period[7:0], req.dat[7:0], req.sel[0]);
            hb = merge_byte({2'b00, ctl.period[13:8]}, req.dat[15:8], req.sel[1]);
            next_ctl.period[13:8] = hb[5:0];
          end
          next_rdat[13:0] = ctl.period;
        end
        // status: outputs, override latch, time base
        ppo_pkg::OFF_STATUS: begin
          next_rdat[ppo_pkg::STAT_PWM_LSB +: 8] = pwm_o;
          next_rdat[ppo_pkg::STAT_OVA_LSB +: 8] = ov_act;
          next_rdat[ppo_pkg::STAT_TB_LSB +: 14] = tb;
        end
        default: begin
          next_rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= '{ovr_en: ppo_pkg::OVR_RST, ovr_lvl: ppo_pkg::OVR_RST,
               period: ppo_pkg::PERIOD_RST};
      for (int i = 0; i < ppo_pkg::N_GEN; i++) begin
        duty[i] <= ppo_pkg::DUTY_RST;
      end
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      ctl <= next_ctl;
      duty <= next_duty;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // time base, compare and override
  assign bnd = (tb >= ctl.period);

  always_comb begin
    next_tb = bnd ? 14'h0000 : tb + 14'h0001;
    next_ps = bnd;
    next_duty_act = duty_act;
    // a dropped enable or level clears the latch at once
    next_ov_act = ov_act & ctl.ovr_en & ctl.ovr_lvl;
    if (bnd) begin
      next_duty_act = duty;
      next_ov_act = ctl.ovr_lvl & ctl.ovr_en;
    end
    // odd outputs are the complement of the even ones
    for (int k = 0; k < ppo_pkg::N_GEN; k++) begin
      base[2*k]   = (tb < duty_act[k]);
      base[2*k+1] = ~(tb < duty_act[k]);
    end
    for (int i = 0; i < ppo_pkg::N_OUT; i++) begin
      if (ctl.ovr_en[i]) begin
        next_pwm[i] = ctl.ovr_lvl[i] & ov_act[i];
      end else begin
        next_pwm[i] = base[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb <= 14'h0000;
      ov_act <= ppo_pkg::OVR_RST;
      for (int i = 0; i < ppo_pkg::N_GEN; i++) begin
        duty_act[i] <= ppo_pkg::DUTY_RST;
      end
      pwm_o <= 8'h00;
      period_start_o <= 1'b0;
    end else begin
      tb <= next_tb;
      ov_act <= next_ov_act;
      duty_act <= next_duty_act;
      pwm_o <= next_pwm;
      period_start_o <= next_ps;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus handshake
  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (
    acc |=> ack_o)
    else $error("request not answered in the next cycle");
  a_ack_unasked: assert property (
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");
  a_unmapped_read: assert property (
    acc && !req.we && req.adr > ppo_pkg::OFF_STATUS |=> dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");

  // duty storage
  a_duty_lo_write: assert property (
    acc && req.we && req.sel[0] && req.adr == ppo_pkg::OFF_DUTY_LO + ppo_pkg::DUTY_STRIDE
    |=> duty[1][7:0] == $past(dat_i[7:0]) ##1 ack_o == 1'b0)
    else $error("low duty byte not stored");
  a_duty_hi_width: assert property (
    acc && req.we && req.sel[0] && req.adr == ppo_pkg::OFF_DUTY_HI
    |=> duty[0][13:8] == $past(dat_i[5:0]))
    else $error("high duty byte not stored in six bits");
  a_hi_read_clean: assert property (
    acc && !req.we && is_duty_adr(req.adr) && req.adr[2]
    |=> dat_o[31:ppo_pkg::HI_W] == '0)
    else $error("high duty read shows bits beyond the field");
  a_duty_copy: assert property (
    bnd |=> duty_act[0] == $past(duty[0]))
    else $error("active duty not loaded at the boundary");
  a_duty_hold: assert property (
    !bnd |=> duty_act[0] == $past(duty_act[0]))
    else $error("active duty changed inside a period");

  // compare and time base
  a_compare_active: assert property (
    !ctl.ovr_en[0] && !$past(ctl.ovr_en[0]) && $past(!rst_i)
    |-> pwm_o[0] == ($past(tb) < $past(duty_act[0])))
    else $error("output does not follow duty compare");
  a_pair_complement: assert property (
    !ctl.ovr_en[2] && !ctl.ovr_en[3] && $past(!ctl.ovr_en[2] && !ctl.ovr_en[3])
    && $past(!rst_i) |-> pwm_o[3] == !pwm_o[2])
    else $error("complementary output mismatch");
  a_zero_duty_off: assert property (
    duty_act[0] == 14'h0000 && !ctl.ovr_en[0] && $past(!ctl.ovr_en[0])
    && $past(duty_act[0] == 14'h0000) && $past(!rst_i) |-> !pwm_o[0])
    else $error("zero duty drove the output active");
  a_tb_wraps: assert property (tb >= ctl.period |=> tb == 14'h0000 && period_start_o)
    else $error("time base failed to wrap");
  a_tb_count: assert property (
    tb < ctl.period |=> tb == $past(tb) + 14'h0001)
    else $error("time base skipped a count");
  a_period_pulse: assert property (
    period_start_o && ctl.period != 14'h0000 |=> !period_start_o)
    else $error("period pulse longer than one cycle");
  a_period_write: assert property (
    acc && req.we && req.sel[1:0] == 2'b11 && req.adr == ppo_pkg::OFF_PERIOD
    |=> ctl.period == $past(dat_i[13:0]))
    else $error("period not stored");

  // override path
  a_override_en: assert property (
    acc && req.we && req.sel[0] && req.adr == ppo_pkg::OFF_OVR_EN
    |=> ctl.ovr_en == $past(dat_i[7:0]))
    else $error("override enable not stored");
  a_override_lvl: assert property (
    acc && req.we && req.sel[0] && req.adr == ppo_pkg::OFF_OVR_LVL
    |=> ctl.ovr_lvl == $past(dat_i[7:0]))
    else $error("override level not stored");
  a_override_low: assert property (
    ctl.ovr_en[0] && !ctl.ovr_lvl[0] |=> !pwm_o[0])
    else $error("override low did not force inactive");
  a_override_wait: assert property (
    ctl.ovr_en[0] && ctl.ovr_lvl[0] && !ov_act[0] && !bnd |=> !pwm_o[0])
    else $error("override high took effect before boundary");
  a_override_high: assert property (
    ctl.ovr_en[0] && ctl.ovr_lvl[0] && ov_act[0] |=> pwm_o[0])
    else $error("override high not driven");
  a_override_clear: assert property (
    !ctl.ovr_en[0] || !ctl.ovr_lvl[0] |=> !ov_act[0])
    else $error("override latch kept without enable and level");
  a_override_latch: assert property (
    ctl.ovr_en[0] && ctl.ovr_lvl[0] && bnd |=> ov_act[0])
    else $error("override level not latched at the boundary");
  a_override_indep: assert property (
    ctl.ovr_en[0] && !ctl.ovr_lvl[0] && $past(ctl.ovr_en[0] && !ctl.ovr_lvl[0])
    && !ctl.ovr_en[1] && $past(!ctl.ovr_en[1]) && $past(!rst_i)
    |-> !pwm_o[0] && pwm_o[1] == ($past(tb) >= $past(duty_act[0])))
    else $error("override leaked between outputs");

  c_write_read: cover property (acc && req.we ##1 ack_o ##[1:4] acc && !req.we);
  c_override_on: cover property (ctl.ovr_en[0] && ctl.ovr_lvl[0] ##[1:300] pwm_o[0]);
  c_override_low: cover property (ctl.ovr_en[0] && !ctl.ovr_lvl[0] ##1 !pwm_o[0]);
  c_full_duty: cover property (duty_act[0] > ctl.period && bnd);
  c_period_wrap: cover property (period_start_o ##[1:300] period_start_o);

endmodule

`default_nettype wire
